/* File: shared/fbp_regs.svh */
`ifndef FBP_REGS_SVH
`define FBP_REGS_SVH
`define FBP_FLASH_BYTES   262144
`define FBP_ERASE_BYTES   1024
`define FBP_PROT_BYTES    2048
`define FBP_ADDR_W        18
`define FBP_UNIT_LSB      11
`define FBP_NUM_UNITS     128
`define FBP_ERASED_WORD   32'hFFFFFFFF
`endif

/* File: shared/fbp_pkg.sv */
package fbp_pkg;
    typedef enum logic [1:0] {
        FBP_PROT_OPEN  = 2'b00,
        FBP_PROT_RDONLY = 2'b01,
        FBP_PROT_XONLY = 2'b10
    } fbp_prot_t;
    typedef enum logic [2:0] {
        FBP_OP_NONE  = 3'b000,
        FBP_OP_FETCH = 3'b001,
        FBP_OP_DREAD = 3'b010,
        FBP_OP_DBGRD = 3'b011,
        FBP_OP_PROG  = 3'b100,
        FBP_OP_ERASE = 3'b101
    } fbp_op_t;
endpackage

/* File: rtl/fbp_prot_table.sv */
`include "fbp_regs.svh"
module fbp_prot_table
    import fbp_pkg::*;
#(
    parameter int UNITS = `FBP_NUM_UNITS
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     set_en,
    input  wire logic [$clog2(UNITS)-1:0] set_unit,
    input  wire fbp_prot_t                set_val,
    input  wire logic [$clog2(UNITS)-1:0] look_unit,
    output fbp_prot_t                     look_val
);
    localparam int IDX_W = $clog2(UNITS);
    fbp_prot_t prot [UNITS];
    genvar g;
    generate
        for (g = 0; g < UNITS; g++) begin : g_unit
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    prot[g] <= FBP_PROT_OPEN;
                end else if (set_en && set_unit == IDX_W'(g)) begin
                    prot[g] <= set_val;
                end
            end
        end
    endgenerate
    assign look_val = prot[look_unit];
endmodule

/* File: rtl/fbp_gate.sv */
// Notes on behaviour
// - Array is 256 KB; every access is decoded against that size.
// - Erase acts on exactly one 1-KB unit, leaving others untouched.
// - An erased unit reads back all ones in every word.
// - Protection is held per pair of erase units, a 2-KB unit.
// - Each protection unit may be open, read-only or execute-only.
// - Read-only units refuse every erase and program request.
// - Execute-only units refuse writes and all reads except instruction fetch.
`include "fbp_regs.svh"
module fbp_gate
    import fbp_pkg::*;
#(
    parameter int ADDR_W = `FBP_ADDR_W,
    parameter int UNITS  = `FBP_NUM_UNITS
) (
    input  wire logic              CORE_CLK,
    input  wire logic              RST_N,
    input  wire logic              REQ_VALID,
    input  wire fbp_op_t           REQ_OP,
    input  wire logic [31:0]       REQ_ADDR,
    input  wire logic [31:0]       REQ_WDATA,
    input  wire logic              PROT_SET,
    input  wire logic [6:0]        PROT_UNIT,
    input  wire fbp_prot_t         PROT_VAL,
    input  wire logic [31:0]       ARR_RDATA,
    output logic                   ARR_RD,
    output logic                   ARR_PROG,
    output logic                   ARR_ERASE,
    output logic [ADDR_W-1:0]      ARR_ADDR,
    output logic [31:0]            ARR_WDATA,
    output logic                   RESP_VALID,
    output logic [31:0]            RESP_RDATA,
    output logic                   RESP_DENIED,
    output logic                   VIOLATION
);
    ////////////////////////////////////////////////////////////////////////
    localparam int EUNITS = 2 * UNITS;
    localparam int EU_W   = $clog2(EUNITS);
    localparam int EU_LSB = $clog2(`FBP_ERASE_BYTES);

    logic [$clog2(UNITS)-1:0] unit;
    logic [EU_W-1:0]          eunit;
    fbp_prot_t                prot;
    logic                     in_range;
    logic                     is_write;
    logic                     is_read;
    logic                     deny;
    logic                     go;
    logic                     rd_go;
    logic                     prog_go;
    logic                     erase_go;
    logic                     blank_hit;
    logic [31:0]              rd_word;
    logic                     rd_pend;
    logic                     rd_blank;
    logic                     ack_pend;
    logic                     deny_pend;
    logic                     blank [EUNITS];

    // Addresses above the array would alias onto low units in the table lookup.
    // The range check refuses them before the lookup result can matter.
    // range decode.
    assign in_range = REQ_ADDR < 32'(`FBP_FLASH_BYTES);
    assign unit     = REQ_ADDR[`FBP_UNIT_LSB +: $clog2(UNITS)];
    assign eunit    = REQ_ADDR[EU_LSB +: EU_W];
    assign is_write = REQ_OP == FBP_OP_PROG || REQ_OP == FBP_OP_ERASE;
    assign is_read  = REQ_OP == FBP_OP_FETCH || REQ_OP == FBP_OP_DREAD || REQ_OP == FBP_OP_DBGRD;
    // A fetch is the only read that an execute-only unit lets through.
    // Writes need an open unit, whichever protection is set.
    // protection check.
    assign deny = !in_range
                || (is_write && prot != FBP_PROT_OPEN)
                || (prot == FBP_PROT_XONLY && is_read && REQ_OP != FBP_OP_FETCH);
    assign go        = REQ_VALID && (is_read || is_write);
    assign rd_go     = go && is_read && !deny;
    assign prog_go   = go && REQ_OP == FBP_OP_PROG && !deny;
    assign erase_go  = go && REQ_OP == FBP_OP_ERASE && !deny;
    assign blank_hit = blank[eunit];
    assign rd_word   = rd_blank ? `FBP_ERASED_WORD : ARR_RDATA;

    fbp_prot_table #(
        .UNITS (UNITS)
    ) u_table (
        .clk       (CORE_CLK),
        .rst_n     (RST_N),
        .set_en    (PROT_SET),
        .set_unit  (PROT_UNIT),
        .set_val   (PROT_VAL),
        .look_unit (unit),
        .look_val  (prot)
    );

    ////////////////////////////////////////////////////////////////////////
    // An erase marks its unit blank and a program clears the mark, so the gate itself
    // guarantees the erased image on reads. Reset leaves every unit unmarked, because
    // the contents before reset are not known.
    genvar e;
    generate
        for (e = 0; e < EUNITS; e++) begin : g_blank
            always_ff @(posedge CORE_CLK) begin
                if (!RST_N) begin
                    blank[e] <= 1'b0;
                end else if (erase_go && eunit == EU_W'(e)) begin
                    blank[e] <= 1'b1;
                end else if (prog_go && eunit == EU_W'(e)) begin
                    blank[e] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ARR_RD    <= 1'b0;
            ARR_PROG  <= 1'b0;
            ARR_ERASE <= 1'b0;
            ARR_ADDR  <= '0;
            ARR_WDATA <= 32'h00000000;
            rd_pend   <= 1'b0;
            rd_blank  <= 1'b0;
            ack_pend  <= 1'b0;
            deny_pend <= 1'b0;
        end else begin
            ARR_RD    <= rd_go;
            ARR_PROG  <= prog_go;
            ARR_ERASE <= erase_go;
            ARR_ADDR  <= REQ_ADDR[ADDR_W-1:0];
            ARR_WDATA <= REQ_WDATA;
            rd_pend   <= rd_go;
            rd_blank  <= rd_go && blank_hit;
            ack_pend  <= go;
            deny_pend <= go && deny;
        end
    end

    // The array answers in the cycle of its read strobe. Every answer leaves two edges after
    // its request, whatever its kind, so a refusal right behind a granted read cannot land
    // on the read's answer.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            RESP_VALID  <= 1'b0;
            RESP_RDATA  <= 32'h00000000;
            RESP_DENIED <= 1'b0;
            VIOLATION   <= 1'b0;
        end else begin
            RESP_VALID  <= ack_pend;
            RESP_RDATA  <= rd_pend ? rd_word : 32'h00000000;
            RESP_DENIED <= deny_pend;
            VIOLATION   <= VIOLATION || (go && deny);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The checks below follow each request through its two stages to the answer.
    sequence s_denied_req;
        REQ_VALID && (is_read || is_write) && deny;
    endsequence

    sequence s_read_grant;
        REQ_VALID && is_read && !deny;
    endsequence

    a_denied_no_touch: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        s_denied_req |=> !ARR_RD && !ARR_PROG && !ARR_ERASE && VIOLATION ##1 RESP_VALID && RESP_DENIED)
        else $error("refused access reached the array");
    a_rdonly_no_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        REQ_VALID && is_write && prot == FBP_PROT_RDONLY |=> !ARR_PROG && !ARR_ERASE)
        else $error("write reached read-only unit");
    a_xonly_fetch_ok: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        REQ_VALID && REQ_OP == FBP_OP_FETCH && prot == FBP_PROT_XONLY && in_range |=> ARR_RD)
        else $error("fetch of execute-only unit refused");
    a_xonly_data_deny: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        REQ_VALID && (REQ_OP == FBP_OP_DREAD || REQ_OP == FBP_OP_DBGRD) && prot == FBP_PROT_XONLY
        |=> ##1 RESP_DENIED && RESP_RDATA == 32'h00000000)
        else $error("execute-only data leaked");
    a_range_deny: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        REQ_VALID && (is_read || is_write) && !in_range |=> ##1 RESP_DENIED)
        else $error("out of range access accepted");
    a_open_erase: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        REQ_VALID && REQ_OP == FBP_OP_ERASE && prot == FBP_PROT_OPEN && in_range
        |=> ARR_ERASE && ARR_ADDR == $past(REQ_ADDR[ADDR_W-1:0]))
        else $error("open erase not issued");
    a_read_timing: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        ARR_RD |=> RESP_VALID && !RESP_DENIED)
        else $error("granted read has no answer");
    a_viol_sticky: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        VIOLATION |=> VIOLATION)
        else $error("violation flag dropped");
    a_xonly_no_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        REQ_VALID && is_write && prot == FBP_PROT_XONLY |=> !ARR_PROG && !ARR_ERASE)
        else $error("write reached execute-only unit");
    a_rdonly_read_ok: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        REQ_VALID && is_read && prot == FBP_PROT_RDONLY && in_range |=> ARR_RD)
        else $error("read of read-only unit refused");
    a_open_prog: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        REQ_VALID && REQ_OP == FBP_OP_PROG && prot == FBP_PROT_OPEN && in_range
        |=> ARR_PROG && ARR_WDATA == $past(REQ_WDATA))
        else $error("open program not issued");
    a_erase_marks: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        erase_go |=> blank[$past(eunit)])
        else $error("erased unit not marked blank");
    a_prog_clears: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        prog_go |=> !blank[$past(eunit)])
        else $error("programmed unit still marked blank");
    a_blank_ones: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        s_read_grant ##0 blank_hit |=> ##1 RESP_RDATA == `FBP_ERASED_WORD)
        else $error("blank unit read not all ones");
    a_answer_two: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        REQ_VALID && (is_read || is_write) |=> ##1 RESP_VALID)
        else $error("request got no answer");
    a_no_idle_answer: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !go |=> ##1 !RESP_VALID)
        else $error("answer without request");
endmodule

/* File: dv/fbp_array_model.sv */
module fbp_array_model (
    input  wire logic        clk,
    input  wire logic        ARR_RD,
    input  wire logic        ARR_PROG,
    input  wire logic        ARR_ERASE,
    input  wire logic [17:0] ARR_ADDR,
    input  wire logic [31:0] ARR_WDATA,
    output logic [31:0]      ARR_RDATA
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] mem [65536];
    // Unwritten words hold their own byte address so an erase is never mistaken for them.
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = {14'h0000, i[15:0], 2'b00};
        end
    end
    // Read data stands in the cycle of the strobe; between reads the port shows the inverse.
    assign ARR_RDATA = ARR_RD ? mem[ARR_ADDR[17:2]] : ~mem[ARR_ADDR[17:2]];
    always @(posedge clk) begin
        if (ARR_PROG) begin
            mem[ARR_ADDR[17:2]] <= ARR_WDATA;
        end
        if (ARR_ERASE) begin
            for (int i = 0; i < 256; i++) begin
                mem[{ARR_ADDR[17:10], i[7:0]}] <= 32'hFFFFFFFF;
            end
        end
    end
endmodule

/* File: dv/flash_block_erase_protect_tb.sv */
module flash_block_erase_protect_tb
    import fbp_pkg::*;
    ();
    timeunit 1ns;
    timeprecision 100ps;
    logic CORE_CLK = 0, RST_N = 0, REQ_VALID = 0, PROT_SET = 0;
    fbp_op_t REQ_OP = FBP_OP_NONE;
    fbp_prot_t PROT_VAL = FBP_PROT_OPEN;
    logic [31:0] REQ_ADDR = 0, REQ_WDATA = 0, ARR_RDATA, ARR_WDATA, RESP_RDATA;
    logic [6:0] PROT_UNIT = 0;
    logic [17:0] ARR_ADDR;
    logic ARR_RD, ARR_PROG, ARR_ERASE, RESP_VALID, RESP_DENIED, VIOLATION;
    int err_count = 0, compares = 0, wcnt = 0;
    logic [31:0] r;
    logic dn;
    fbp_gate dut_u (.CORE_CLK, .RST_N, .REQ_VALID, .REQ_OP, .REQ_ADDR, .REQ_WDATA, .PROT_SET, .PROT_UNIT,
        .PROT_VAL, .ARR_RDATA, .ARR_RD, .ARR_PROG, .ARR_ERASE, .ARR_ADDR, .ARR_WDATA, .RESP_VALID,
        .RESP_RDATA, .RESP_DENIED, .VIOLATION);
    fbp_array_model arr_u (.clk(CORE_CLK), .ARR_RD, .ARR_PROG, .ARR_ERASE, .ARR_ADDR, .ARR_WDATA, .ARR_RDATA);
    initial forever #12.5 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) wcnt <= wcnt + ARR_PROG + ARR_ERASE;
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (err_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        compares++;
        if (s !== e) begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
            err_count++;
        end
    endtask
    task automatic op(input fbp_op_t o, input logic [31:0] a, input logic [31:0] d);
        int n = 0;
        REQ_VALID = 1'b1;
        REQ_OP    = o;
        REQ_ADDR  = a;
        REQ_WDATA = d;
        @(negedge CORE_CLK) REQ_VALID = 0;
        while (RESP_VALID !== 1'b1 && n < 4) begin
            @(negedge CORE_CLK);
            n++;
        end
        if (n == 4) begin
            err_count++;
            tally_and_finish();
        end
        {r, dn} = {RESP_RDATA, RESP_DENIED};
    endtask
    task automatic set(input logic [6:0] u, input fbp_prot_t v);
        PROT_SET  = 1'b1;
        PROT_UNIT = u;
        PROT_VAL  = v;
        @(negedge CORE_CLK) PROT_SET = 0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_open;
        chk(VIOLATION, 0);
        op(FBP_OP_PROG, 32'h800, 32'h12345678);
        op(FBP_OP_DREAD, 32'h800, 0);
        chk(r, 32'h12345678);
        op(FBP_OP_ERASE, 32'h800, 0);
        op(FBP_OP_DREAD, 32'hBFC, 0);
        chk(r, `FBP_ERASED_WORD);
        op(FBP_OP_DBGRD, 32'h800, 0);
        chk(r, `FBP_ERASED_WORD);
        op(FBP_OP_DREAD, 32'hC00, 0);
        chk(r, 32'hC00);
        op(FBP_OP_FETCH, 32'h7FC, 0);
        chk(r, 32'h7FC);
        op(FBP_OP_FETCH, 32'h3FFFC, 0);
        chk({dn, r}, {1'b0, 32'h3FFFC});
        op(FBP_OP_DREAD, 32'h40000, 0);
        chk(dn, 1);
    endtask
    task automatic t_rdonly;
        int w;
        set(7'h02, FBP_PROT_RDONLY);
        w = wcnt;
        op(FBP_OP_PROG, 32'h1000, 0);
        chk(dn, 1);
        op(FBP_OP_ERASE, 32'h17FC, 0);
        chk({dn, VIOLATION}, 2'b11);
        op(FBP_OP_DREAD, 32'h1000, 0);
        chk({dn, r}, {1'b0, 32'h1000});
        chk(wcnt, w);
        op(FBP_OP_PROG, 32'h1800, 0);
        op(FBP_OP_DREAD, 32'h1800, 0);
        chk({dn, r}, 33'h0);
    endtask
    task automatic t_xonly;
        set(7'h04, FBP_PROT_XONLY);
        op(FBP_OP_FETCH, 32'h2000, 0);
        chk({dn, r}, {1'b0, 32'h2000});
        op(FBP_OP_DREAD, 32'h2000, 0);
        chk({dn, r}, {1'b1, 32'h0});
        op(FBP_OP_DBGRD, 32'h27FC, 0);
        chk({dn, r}, {1'b1, 32'h0});
        op(FBP_OP_ERASE, 32'h2400, 0);
        chk(dn, 1);
        op(FBP_OP_FETCH, 32'h2400, 0);
        chk(r, 32'h2400);
    endtask
    // A granted read and a refusal on consecutive edges must answer one after the other.
    task automatic t_b2b;
        REQ_VALID = 1'b1;
        REQ_OP    = FBP_OP_DREAD;
        REQ_ADDR  = 32'h1004;
        @(negedge CORE_CLK);
        REQ_ADDR  = 32'h2004;
        @(negedge CORE_CLK);
        REQ_VALID = 1'b0;
        chk({RESP_VALID, RESP_DENIED, RESP_RDATA}, {2'b10, 32'h1004});
        @(negedge CORE_CLK);
        chk({RESP_VALID, RESP_DENIED, RESP_RDATA}, {2'b11, 32'h0});
    endtask
    task automatic t_reset;
        RST_N = 1'b0;
        repeat (2) @(negedge CORE_CLK);
        RST_N = 1'b1;
        chk(VIOLATION, 0);
        op(FBP_OP_PROG, 32'h2000, 32'h0000A5A5);
        chk(dn, 0);
        op(FBP_OP_FETCH, 32'h2000, 0);
        chk({dn, r}, {1'b0, 32'h0000A5A5});
        op(FBP_OP_DREAD, 32'h40000, 0);
        chk({dn, VIOLATION}, 2'b11);
    endtask
    initial begin
        repeat (3) @(negedge CORE_CLK);
        RST_N = 1;
        t_open();
        t_rdonly();
        t_xonly();
        t_b2b();
        t_reset();
        tally_and_finish();
    end
endmodule
